// ===== verilog/apm_pkg.sv
package apm_pkg;
    // register byte offsets from the block base
    localparam logic [3:0] OFF_STS_LOW  = 4'h0;
    localparam logic [3:0] OFF_STS_HIGH = 4'h1;
    localparam logic [3:0] OFF_EN_LOW   = 4'h2;
    localparam logic [3:0] OFF_EN_HIGH  = 4'h3;
    localparam logic [3:0] OFF_CTL0     = 4'h4;
    localparam logic [3:0] OFF_CTL1     = 4'h5;
    localparam logic [3:0] OFF_CTL2     = 4'h6;
    localparam logic [3:0] OFF_CTL3     = 4'h7;
    localparam logic [3:0] OFF_TMR0     = 4'h8;
    localparam logic [3:0] OFF_TMR1     = 4'h9;
    localparam logic [3:0] OFF_TMR2     = 4'hA;
    localparam logic [3:0] OFF_TMR3     = 4'hB;
    // field positions
    localparam int BIT_CARRY_STAT  = 0;
    localparam int BIT_BUSM_STAT   = 4;
    localparam int BIT_GLOBAL_STAT = 5;
    localparam int BIT_WAKE        = 7;
    localparam int BIT_CARRY_EN    = 0;
    localparam int BIT_GLOBAL_EN   = 5;
    localparam int BIT_ROUTE       = 0;
    localparam int BIT_BUSM_RELOAD = 1;
    localparam int BIT_GLOBAL_REL  = 2;
    localparam int BYTE_WIDTH   = 8;
    localparam int TMR_WIDTH    = 24;
    localparam int TMR_MSB      = 23;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    // sleep/work states
    typedef enum logic [0:0] {
        ST_SLEEP = 1'b0,
        ST_WORK  = 1'b1
    } apm_state_type;
endpackage : apm_pkg

// ===== verilog/apm_timer.sv
`timescale 1ns/1ps
// 24-bit up counter advanced on timer ticks while working
module apm_timer #(
    parameter int WIDTH = apm_pkg::TMR_WIDTH
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             tick_i,
    input  wire logic             run_i,
    output logic      [WIDTH-1:0] count_o,
    output logic                  msb_flip_o
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic             flip_reg;
    logic             flip_next;

    // a stopped tick simply holds the count, so counting resumes in place
    always_comb begin
        count_next = count_reg;
        flip_next  = 1'b0;
        if (tick_i && run_i) begin
            count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            flip_next  = count_next[WIDTH-1] ^ count_reg[WIDTH-1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            count_reg <= '0;
            flip_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            flip_reg  <= flip_next;
        end
    end

    assign count_o    = count_reg;
    assign msb_flip_o = flip_reg;
endmodule : apm_timer

// ===== verilog/apm_block.sv
`timescale 1ns/1ps
// Summary of operation
// - wake flag set only by resume event while sleeping
// - wake flag set moves system to working
// - wake cleared by write one or standby expiry
// - wake clear and all asleep: chip sleeps
// - timer carry status with enable raises event
// - global enable and status raise event
// - route select picks control or management interrupt
// - reload enable and busmaster control raise interrupt
// - global release sets firmware status, maybe management interrupt
// - reserved bits and registers read zero
// - 24-bit timer readable at bytes 8,9,A
// - timer counts only while working
// - timer holds count while its clock stops
// - carry status set on each bit-23 change
// - carry status cleared only by writing one
// - firmware release sets itself and global status
// - busmaster control sets itself and busmaster status
// - firmware status clear input clears it and release
module apm_block #(
    parameter int TMR_WIDTH = apm_pkg::TMR_WIDTH
) (
    input  wire logic       CLK_I,
    input  wire logic       NRST_I,
    input  wire logic [3:0] ADDR_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic [7:0] WDATA_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       TMR_TICK_I,
    input  wire logic       RESUME_EVENT_I,
    input  wire logic       STANDBY_EXPIRED_I,
    input  wire logic       ALL_FUNCS_ASLEEP_I,
    input  wire logic       FIRMWARE_RELEASE_SET_I,
    input  wire logic       BUSMASTER_CONTROL_SET_I,
    input  wire logic       FIRMWARE_STATUS_CLR_I,
    input  wire logic       FIRMWARE_SIDE_ENABLE_I,
    input  wire logic       MGMT_INTERRUPT_ENABLE_I,
    output logic            FIRMWARE_SIDE_STATUS_O,
    output logic            WORKING_O,
    output logic            SCI_O,
    output logic            SMI_O
);
    logic                          wake_reg, wake_next;
    logic                          tsts_reg, tsts_next;
    logic                          bmsts_reg, bmsts_next;
    logic                          gsts_reg, gsts_next;
    logic                          ten_reg, ten_next;
    logic                          gen_reg, gen_next;
    logic                          route_reg, route_next;
    logic                          rld_reg, rld_next;
    logic                          grls_reg, grls_next;
    logic                          bmctl_reg, bmctl_next;
    logic                          frls_reg, frls_next;
    logic                          fsts_reg, fsts_next;
    apm_pkg::apm_state_type        state_reg, state_next;
    logic [7:0]                    rdata_reg, rdata_next;
    logic [TMR_WIDTH-1:0]          count;
    logic [apm_pkg::TMR_WIDTH-1:0] count_wide;
    logic                          msb_flip;
    logic                          pm_event;

    // helper: write-one strobe for a bit of a given register
    function automatic logic w1(input logic [3:0] a, input logic [3:0] off,
                                input logic wr, input logic [7:0] d, input int b);
        return wr && (a == off) && d[b];
    endfunction : w1

    // a narrow counter is read through the full byte map with its upper bits zero
    localparam int FULL_W = apm_pkg::TMR_WIDTH;

    // timer byte named by an offset counted from the first timer byte
    function automatic logic [7:0] timer_byte(input logic [FULL_W-1:0] c, input logic [3:0] a);
        int idx;
        idx = int'(a - apm_pkg::OFF_TMR0);
        return c[idx*apm_pkg::BYTE_WIDTH +: apm_pkg::BYTE_WIDTH];
    endfunction : timer_byte

    apm_timer #(
        .WIDTH (TMR_WIDTH)
    ) u_timer (
        .clk_i      (CLK_I),
        .nrst_i     (NRST_I),
        .tick_i     (TMR_TICK_I),
        .run_i      (state_reg == apm_pkg::ST_WORK),
        .count_o    (count),
        .msb_flip_o (msb_flip)
    );

    // status, enable and control next values; hardware sets win over clears
    always_comb begin
        wake_next  = wake_reg;
        tsts_next  = tsts_reg;
        bmsts_next = bmsts_reg;
        gsts_next  = gsts_reg;
        ten_next   = ten_reg;
        gen_next   = gen_reg;
        route_next = route_reg;
        rld_next   = rld_reg;
        grls_next  = grls_reg;
        bmctl_next = bmctl_reg;
        frls_next  = frls_reg;
        fsts_next  = fsts_reg;
        state_next = state_reg;
        // write-one clears, plus standby expiry and the firmware status clear input
        if (w1(ADDR_I, apm_pkg::OFF_STS_HIGH, WR_I, WDATA_I, apm_pkg::BIT_WAKE) || STANDBY_EXPIRED_I)
            wake_next = 1'b0;
        if (w1(ADDR_I, apm_pkg::OFF_STS_LOW, WR_I, WDATA_I, apm_pkg::BIT_CARRY_STAT))
            tsts_next = 1'b0;
        if (w1(ADDR_I, apm_pkg::OFF_STS_LOW, WR_I, WDATA_I, apm_pkg::BIT_BUSM_STAT)) begin
            bmsts_next = 1'b0;
            bmctl_next = 1'b0;
        end
        if (w1(ADDR_I, apm_pkg::OFF_STS_LOW, WR_I, WDATA_I, apm_pkg::BIT_GLOBAL_STAT)) begin
            gsts_next = 1'b0;
            frls_next = 1'b0;
        end
        if (FIRMWARE_STATUS_CLR_I) begin
            fsts_next = 1'b0;
            grls_next = 1'b0;
        end
        // plain read/write fields
        if (WR_I && ADDR_I == apm_pkg::OFF_EN_LOW) begin
            ten_next = WDATA_I[apm_pkg::BIT_CARRY_EN];
            gen_next = WDATA_I[apm_pkg::BIT_GLOBAL_EN];
        end
        if (WR_I && ADDR_I == apm_pkg::OFF_CTL0) begin
            route_next = WDATA_I[apm_pkg::BIT_ROUTE];
            rld_next   = WDATA_I[apm_pkg::BIT_BUSM_RELOAD];
        end
        // sets come last so they win over a clear in the same cycle
        if (msb_flip)
            tsts_next = 1'b1;
        if (w1(ADDR_I, apm_pkg::OFF_CTL0, WR_I, WDATA_I, apm_pkg::BIT_GLOBAL_REL)) begin
            grls_next = 1'b1;
            fsts_next = 1'b1;
        end
        if (FIRMWARE_RELEASE_SET_I) begin
            frls_next = 1'b1;
            gsts_next = 1'b1;
        end
        if (BUSMASTER_CONTROL_SET_I) begin
            bmctl_next = 1'b1;
            bmsts_next = 1'b1;
        end
        // sleep/work machine
        case (state_reg)
            apm_pkg::ST_SLEEP: begin
                if (RESUME_EVENT_I) begin
                    wake_next  = 1'b1;
                    state_next = apm_pkg::ST_WORK;
                end
            end
            apm_pkg::ST_WORK: begin
                if (!wake_reg && ALL_FUNCS_ASLEEP_I)
                    state_next = apm_pkg::ST_SLEEP;
            end
            default: state_next = apm_pkg::ST_SLEEP;
        endcase
    end

    // read mux; registered data, reserved bits and registers give zero
    always_comb begin
        rdata_next = apm_pkg::ZERO_BYTE;
        if (RD_I) begin
            case (ADDR_I)
                apm_pkg::OFF_STS_LOW: begin
                    rdata_next[apm_pkg::BIT_CARRY_STAT]  = tsts_reg;
                    rdata_next[apm_pkg::BIT_BUSM_STAT]   = bmsts_reg;
                    rdata_next[apm_pkg::BIT_GLOBAL_STAT] = gsts_reg;
                end
                apm_pkg::OFF_STS_HIGH: rdata_next[apm_pkg::BIT_WAKE] = wake_reg;
                apm_pkg::OFF_EN_LOW: begin
                    rdata_next[apm_pkg::BIT_CARRY_EN]  = ten_reg;
                    rdata_next[apm_pkg::BIT_GLOBAL_EN] = gen_reg;
                end
                apm_pkg::OFF_CTL0: begin
                    rdata_next[apm_pkg::BIT_ROUTE]   = route_reg;
                    rdata_next[apm_pkg::BIT_BUSM_RELOAD] = rld_reg;
                    rdata_next[apm_pkg::BIT_GLOBAL_REL]  = grls_reg;
                end
                apm_pkg::OFF_TMR0: rdata_next = timer_byte(count_wide, ADDR_I);
                apm_pkg::OFF_TMR1: rdata_next = timer_byte(count_wide, ADDR_I);
                apm_pkg::OFF_TMR2: rdata_next = timer_byte(count_wide, ADDR_I);
                default: rdata_next = apm_pkg::ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            wake_reg  <= 1'b0;
            tsts_reg  <= 1'b0;
            bmsts_reg <= 1'b0;
            gsts_reg  <= 1'b0;
            ten_reg   <= 1'b0;
            gen_reg   <= 1'b0;
            route_reg <= 1'b0;
            rld_reg   <= 1'b0;
            grls_reg  <= 1'b0;
            bmctl_reg <= 1'b0;
            frls_reg  <= 1'b0;
            fsts_reg  <= 1'b0;
            state_reg <= apm_pkg::ST_SLEEP;
            rdata_reg <= apm_pkg::RESET_BYTE;
        end else begin
            wake_reg  <= wake_next;
            tsts_reg  <= tsts_next;
            bmsts_reg <= bmsts_next;
            gsts_reg  <= gsts_next;
            ten_reg   <= ten_next;
            gen_reg   <= gen_next;
            route_reg <= route_next;
            rld_reg   <= rld_next;
            grls_reg  <= grls_next;
            bmctl_reg <= bmctl_next;
            frls_reg  <= frls_next;
            fsts_reg  <= fsts_next;
            state_reg <= state_next;
            rdata_reg <= rdata_next;
        end
    end

    // interrupt levels follow the flags, so they drop when software clears them
    assign pm_event = (tsts_reg && ten_reg) || (gen_reg && gsts_reg);
    assign SCI_O    = (route_reg && pm_event) || (rld_reg && bmctl_reg);
    assign SMI_O    = (!route_reg && MGMT_INTERRUPT_ENABLE_I && pm_event)
                    || (fsts_reg && FIRMWARE_SIDE_ENABLE_I);
    assign FIRMWARE_SIDE_STATUS_O = fsts_reg;
    assign WORKING_O = (state_reg == apm_pkg::ST_WORK);
    assign RDATA_O   = rdata_reg;
    assign count_wide = FULL_W'(count); // zero-extends a short counter on purpose

    // interrupt levels against the flags and enables behind them
    AST_TMR_EVENT: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (tsts_reg && ten_reg && route_reg) |-> SCI_O) else $error("timer event lost");
    AST_TMR_MASK: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (!ten_reg && !gsts_reg && !(rld_reg && bmctl_reg)) |-> !SCI_O) else $error("masked sci");
    AST_GBL_SCI: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (gen_reg && gsts_reg && route_reg) |-> SCI_O) else $error("global sci missing");
    AST_BM_SCI: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (rld_reg && bmctl_reg) |-> SCI_O) else $error("busmaster sci missing");
    AST_SMI_ROUTE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (!route_reg && MGMT_INTERRUPT_ENABLE_I && pm_event) |-> SMI_O) else $error("management route lost");
    AST_SCI_ROUTE_OFF: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (!route_reg && !(rld_reg && bmctl_reg)) |-> !SCI_O) else $error("event leaked to sci");
    AST_SMI_FIRM: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (fsts_reg && FIRMWARE_SIDE_ENABLE_I) |-> SMI_O) else $error("firmware smi missing");
    AST_SCI_DROP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (!pm_event && !(rld_reg && bmctl_reg)) |-> !SCI_O) else $error("sci stuck");
    AST_SMI_DROP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (!pm_event && !fsts_reg) |-> !SMI_O) else $error("smi stuck");

    // sleep/work machine and the wake flag
    AST_WAKE_WORK: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        $rose(wake_reg) |-> WORKING_O) else $error("wake without work");
    AST_WAKE_ONLY_SLEEP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        $rose(wake_reg) |-> $past(state_reg) == apm_pkg::ST_SLEEP) else $error("bad wake set");
    sequence s_wake_clear;
        (w1(ADDR_I, apm_pkg::OFF_STS_HIGH, WR_I, WDATA_I, apm_pkg::BIT_WAKE) || STANDBY_EXPIRED_I)
        && !(state_reg == apm_pkg::ST_SLEEP && RESUME_EVENT_I);
    endsequence
    AST_WAKE_CLEAR: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        s_wake_clear |=> !wake_reg) else $error("wake not cleared");
    AST_WAKE_KEEP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (wake_reg && !STANDBY_EXPIRED_I && !w1(ADDR_I, apm_pkg::OFF_STS_HIGH, WR_I, WDATA_I, apm_pkg::BIT_WAKE))
        |=> wake_reg) else $error("wake lost");
    AST_SLEEP_ENTRY: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (WORKING_O && !wake_reg && ALL_FUNCS_ASLEEP_I) |=> !WORKING_O) else $error("sleep missed");

    // paired release and busmaster flags
    sequence s_rls_write;
        WR_I && ADDR_I == apm_pkg::OFF_CTL0 && WDATA_I[apm_pkg::BIT_GLOBAL_REL];
    endsequence
    AST_RLS_SETS: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        s_rls_write |=> (fsts_reg && grls_reg)) else $error("release not set");
    AST_FRLS_SETS: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        FIRMWARE_RELEASE_SET_I |=> (frls_reg && gsts_reg)) else $error("firmware release not set");
    AST_GSTS_KEEP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (gsts_reg && !w1(ADDR_I, apm_pkg::OFF_STS_LOW, WR_I, WDATA_I, apm_pkg::BIT_GLOBAL_STAT))
        |=> gsts_reg) else $error("global status lost");
    AST_BMCTL_SETS: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        BUSMASTER_CONTROL_SET_I |=> (bmctl_reg && bmsts_reg)) else $error("busmaster pair not set");
    AST_BMSTS_KEEP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (bmsts_reg && !w1(ADDR_I, apm_pkg::OFF_STS_LOW, WR_I, WDATA_I, apm_pkg::BIT_BUSM_STAT))
        |=> bmsts_reg) else $error("busmaster status lost");
    AST_FSTS_CLEAR: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (FIRMWARE_STATUS_CLR_I && !w1(ADDR_I, apm_pkg::OFF_CTL0, WR_I, WDATA_I, apm_pkg::BIT_GLOBAL_REL))
        |=> (!fsts_reg && !grls_reg)) else $error("firmware status not cleared");
    AST_FSTS_KEEP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (fsts_reg && !FIRMWARE_STATUS_CLR_I) |=> fsts_reg) else $error("firmware status lost");

    // timer count and its carry status
    AST_CARRY_SET: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        msb_flip |=> tsts_reg) else $error("carry status not set");
    AST_CARRY_KEEP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (tsts_reg && !w1(ADDR_I, apm_pkg::OFF_STS_LOW, WR_I, WDATA_I, apm_pkg::BIT_CARRY_STAT))
        |=> tsts_reg) else $error("carry status lost");
    AST_TMR_RUN: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (TMR_TICK_I && WORKING_O) |=> !$stable(count)) else $error("timer did not count");
    AST_TMR_IDLE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        !WORKING_O |=> $stable(count)) else $error("timer counted asleep");
    AST_TMR_HOLD: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (!TMR_TICK_I && !$past(TMR_TICK_I)) |=> $stable(count)) else $error("timer moved");
    AST_RSVD_ZERO: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (RD_I && ADDR_I == apm_pkg::OFF_TMR3) |=> RDATA_O == apm_pkg::ZERO_BYTE) else $error("rsvd");
endmodule : apm_block

// ===== dv/apm_block_tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            $display("[ERR] %s expected %h seen %h", nm, exp, got); \
            bad_count++; \
        end \
    end
module acpi_pm1_event_control_timer_tb;
    typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} apm_row_type;
    logic       CLK_I = 1'b0, NRST_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0, TMR_TICK_I = 1'b0;
    logic       RESUME_EVENT_I = 1'b0, STANDBY_EXPIRED_I = 1'b0, ALL_FUNCS_ASLEEP_I = 1'b0;
    logic       FIRMWARE_RELEASE_SET_I = 1'b0, BUSMASTER_CONTROL_SET_I = 1'b0, FIRMWARE_STATUS_CLR_I = 1'b0;
    logic       FIRMWARE_SIDE_ENABLE_I = 1'b0, MGMT_INTERRUPT_ENABLE_I = 1'b0;
    logic [3:0] ADDR_I = 4'h0;
    logic [7:0] WDATA_I = 8'h00;
    logic [7:0] RDATA_O;
    logic       FIRMWARE_SIDE_STATUS_O, WORKING_O, SCI_O, SMI_O;
    int         bad_count = 0;
    int         n_tests = 0;
    // writes to reserved bits and read-only bytes must not stick
    apm_row_type rows [14] = '{'{4'h2, 8'hFF, 8'h21}, '{4'h3, 8'hFF, 8'h00}, '{4'h4, 8'hF3, 8'h03},
        '{4'h5, 8'hFF, 8'h00}, '{4'h6, 8'hFF, 8'h00}, '{4'h7, 8'hFF, 8'h00}, '{4'h8, 8'hFF, 8'h00},
        '{4'h9, 8'hFF, 8'h00}, '{4'hA, 8'hFF, 8'h00}, '{4'hB, 8'hFF, 8'h00}, '{4'h1, 8'h7F, 8'h00},
        '{4'h0, 8'hCE, 8'h00}, '{4'h2, 8'h00, 8'h00}, '{4'h4, 8'h00, 8'h00}};

    // a 9-bit counter lets the carry flip inside the run; the timer bytes read zero above bit 8
    apm_block #(.TMR_WIDTH(9)) DUT (.CLK_I(CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
        .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .TMR_TICK_I(TMR_TICK_I), .RESUME_EVENT_I(RESUME_EVENT_I),
        .STANDBY_EXPIRED_I(STANDBY_EXPIRED_I), .ALL_FUNCS_ASLEEP_I(ALL_FUNCS_ASLEEP_I),
        .FIRMWARE_RELEASE_SET_I(FIRMWARE_RELEASE_SET_I), .BUSMASTER_CONTROL_SET_I(BUSMASTER_CONTROL_SET_I),
        .FIRMWARE_STATUS_CLR_I(FIRMWARE_STATUS_CLR_I), .FIRMWARE_SIDE_ENABLE_I(FIRMWARE_SIDE_ENABLE_I),
        .MGMT_INTERRUPT_ENABLE_I(MGMT_INTERRUPT_ENABLE_I), .FIRMWARE_SIDE_STATUS_O(FIRMWARE_SIDE_STATUS_O),
        .WORKING_O(WORKING_O), .SCI_O(SCI_O), .SMI_O(SMI_O));

    // 20 MHz system clock
    initial begin
        forever #25 CLK_I = ~CLK_I;
    end

    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // inputs move on the falling edge so the rising edge sees them settled
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge CLK_I);
        ADDR_I = a;
        WDATA_I = d;
        WR_I = 1'b1;
        @(negedge CLK_I);
        WR_I = 1'b0;
    endtask : wr

    // read data is registered, so it is looked at one cycle after the strobe
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        @(negedge CLK_I);
        ADDR_I = a;
        RD_I = 1'b1;
        @(negedge CLK_I);
        RD_I = 1'b0;
        `CHK("RDATA_O", e, RDATA_O)
    endtask : rdchk

    task automatic chk_zero;
        for (int i = 0; i < 12; i++) rdchk(4'(i), 8'h00);
        `CHK("WORKING_O", 1'b0, WORKING_O)
        `CHK("SCI_O", 1'b0, SCI_O)
        `CHK("SMI_O", 1'b0, SMI_O)
        `CHK("FIRMWARE_SIDE_STATUS_O", 1'b0, FIRMWARE_SIDE_STATUS_O)
    endtask : chk_zero

    task automatic do_reset;
        NRST_I = 1'b0;
        repeat (12) @(negedge CLK_I);
        NRST_I = 1'b1;
    endtask : do_reset

    // one timer tick every second cycle, like the slow clock synchronised
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge CLK_I) TMR_TICK_I = 1'b1;
            @(negedge CLK_I) TMR_TICK_I = 1'b0;
        end
    endtask : ticks

    // bounded wait: the state change may lag the flag by a cycle
    task automatic wait_work(input logic e);
        for (int i = 0; i < 8 && WORKING_O !== e; i++) @(negedge CLK_I);
        `CHK("WORKING_O", e, WORKING_O)
        if (WORKING_O !== e) stop_test();
    endtask : wait_work

    // watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge CLK_I);
        bad_count++;
        stop_test();
    end

    initial begin
        do_reset();
        chk_zero();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rdchk(rows[i].a, rows[i].e);
        end
        // resume while asleep wakes the chip
        @(negedge CLK_I) RESUME_EVENT_I = 1'b1;
        @(negedge CLK_I) RESUME_EVENT_I = 1'b0;
        rdchk(apm_pkg::OFF_STS_HIGH, 8'h80);
        wait_work(1'b1);
        ticks(5);
        rdchk(apm_pkg::OFF_TMR0, 8'h05);
        repeat (10) @(negedge CLK_I);
        rdchk(apm_pkg::OFF_TMR0, 8'h05);
        wr(apm_pkg::OFF_STS_HIGH, 8'h00);
        rdchk(apm_pkg::OFF_STS_HIGH, 8'h80);
        wr(apm_pkg::OFF_STS_HIGH, 8'h80);
        rdchk(apm_pkg::OFF_STS_HIGH, 8'h00);
        @(negedge CLK_I) ALL_FUNCS_ASLEEP_I = 1'b1;
        wait_work(1'b0);
        ticks(3);
        rdchk(apm_pkg::OFF_TMR0, 8'h05);
        ALL_FUNCS_ASLEEP_I = 1'b0;
        @(negedge CLK_I) RESUME_EVENT_I = 1'b1;
        @(negedge CLK_I) RESUME_EVENT_I = 1'b0;
        wait_work(1'b1);
        @(negedge CLK_I) STANDBY_EXPIRED_I = 1'b1;
        @(negedge CLK_I) STANDBY_EXPIRED_I = 1'b0;
        rdchk(apm_pkg::OFF_STS_HIGH, 8'h00);
        // a resume while already working must not set the flag
        @(negedge CLK_I) RESUME_EVENT_I = 1'b1;
        @(negedge CLK_I) RESUME_EVENT_I = 1'b0;
        rdchk(apm_pkg::OFF_STS_HIGH, 8'h00);
        ticks(256);
        rdchk(apm_pkg::OFF_TMR0, 8'h05);
        rdchk(apm_pkg::OFF_TMR1, 8'h01);
        rdchk(apm_pkg::OFF_TMR2, 8'h00);
        // count 261 has crossed the short counter's top bit, so the carry status is up
        rdchk(apm_pkg::OFF_STS_LOW, 8'h01);
        wr(apm_pkg::OFF_CTL0, 8'h01);
        `CHK("SCI_O", 1'b0, SCI_O)
        wr(apm_pkg::OFF_EN_LOW, 8'h01);
        `CHK("SCI_O", 1'b1, SCI_O)
        wr(apm_pkg::OFF_STS_LOW, 8'h00);
        `CHK("SCI_O", 1'b1, SCI_O)
        wr(apm_pkg::OFF_STS_LOW, 8'h01);
        `CHK("SCI_O", 1'b0, SCI_O)
        rdchk(apm_pkg::OFF_STS_LOW, 8'h00);
        // global event, first as control interrupt then as management
        wr(apm_pkg::OFF_EN_LOW, 8'h20);
        wr(apm_pkg::OFF_CTL0, 8'h01);
        @(negedge CLK_I) FIRMWARE_RELEASE_SET_I = 1'b1;
        @(negedge CLK_I) FIRMWARE_RELEASE_SET_I = 1'b0;
        `CHK("SCI_O", 1'b1, SCI_O)
        `CHK("SMI_O", 1'b0, SMI_O)
        rdchk(apm_pkg::OFF_STS_LOW, 8'h20);
        wr(apm_pkg::OFF_STS_LOW, 8'h00);
        `CHK("SCI_O", 1'b1, SCI_O)
        MGMT_INTERRUPT_ENABLE_I = 1'b1;
        wr(apm_pkg::OFF_CTL0, 8'h00);
        `CHK("SMI_O", 1'b1, SMI_O)
        `CHK("SCI_O", 1'b0, SCI_O)
        wr(apm_pkg::OFF_STS_LOW, 8'h20);
        `CHK("SMI_O", 1'b0, SMI_O)
        rdchk(apm_pkg::OFF_STS_LOW, 8'h00);
        MGMT_INTERRUPT_ENABLE_I = 1'b0;
        wr(apm_pkg::OFF_EN_LOW, 8'h00);
        // bus master reload path
        wr(apm_pkg::OFF_CTL0, 8'h03);
        @(negedge CLK_I) BUSMASTER_CONTROL_SET_I = 1'b1;
        @(negedge CLK_I) BUSMASTER_CONTROL_SET_I = 1'b0;
        `CHK("SCI_O", 1'b1, SCI_O)
        rdchk(apm_pkg::OFF_STS_LOW, 8'h10);
        wr(apm_pkg::OFF_STS_LOW, 8'h10);
        `CHK("SCI_O", 1'b0, SCI_O)
        // release toward the firmware side
        FIRMWARE_SIDE_ENABLE_I = 1'b1;
        wr(apm_pkg::OFF_CTL0, 8'h04);
        `CHK("FIRMWARE_SIDE_STATUS_O", 1'b1, FIRMWARE_SIDE_STATUS_O)
        `CHK("SMI_O", 1'b1, SMI_O)
        rdchk(apm_pkg::OFF_CTL0, 8'h04);
        @(negedge CLK_I) FIRMWARE_STATUS_CLR_I = 1'b1;
        @(negedge CLK_I) FIRMWARE_STATUS_CLR_I = 1'b0;
        `CHK("FIRMWARE_SIDE_STATUS_O", 1'b0, FIRMWARE_SIDE_STATUS_O)
        `CHK("SMI_O", 1'b0, SMI_O)
        rdchk(apm_pkg::OFF_CTL0, 8'h00);
        // second reset in mid-run with state loaded
        wr(apm_pkg::OFF_EN_LOW, 8'h21);
        wr(apm_pkg::OFF_CTL0, 8'h03);
        do_reset();
        chk_zero();
        stop_test();
    end
endmodule : acpi_pm1_event_control_timer_tb
